// file: logic/vsgr_device.sv
// device end: two channel gain control words behind the serial link
`include "vsgr_defs.svh"
`default_nettype none
module vsgr_device
(
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              clk_en_i,
   vsgr_link_if.dev               link,
   input  wire logic              power_up_ch_a_i,
   input  wire logic              power_up_ch_b_i,
   input  wire logic              attack_trigger_ch_a_i,
   input  wire logic              attack_trigger_ch_b_i,
   input  wire logic              iface_sel_hi_i,
   input  wire logic              iface_sel_lo_i,
   output wire logic [1:0][5:0]   gain_code_o,
   output wire logic [1:0][1:0]   attack_sel_o,
   output wire logic [1:0][5:0]   applied_code_o,
   output wire logic [1:0][6:0]   gain_half_db_o,
   output wire logic [1:0]        amp_on_o,
   output wire logic [1:0]        read_pending_o
);

   // attenuation step in code units: 2 dB is four half-dB codes
   function automatic logic [6:0] attack_step(input logic [1:0] sel);
      attack_step = `VSGR_STEP_BASE << sel;
   endfunction : attack_step

   // word shifted out on readback; ignored positions read as zero
   function automatic logic [15:0] pack_word(input logic [1:0] atk,
                                             input logic [5:0] gain);
      pack_word = {8'h00, atk, gain};
   endfunction : pack_word

   logic [9:0] sync1_reg;
   logic [9:0] sync2_reg;
   logic       sclk_d_reg;
   logic       sdio_out_reg;
   logic       sdio_oe_reg;

   wire logic [9:0] pins_w = {iface_sel_hi_i, iface_sel_lo_i,
                              attack_trigger_ch_b_i, attack_trigger_ch_a_i,
                              power_up_ch_b_i, power_up_ch_a_i,
                              link.sel_b_n, link.sel_a_n,
                              link.sdio, link.sclk};

   wire logic       sclk_s    = sync2_reg[0];
   wire logic       sdio_s    = sync2_reg[1];
   wire logic [1:0] sel_n_s   = sync2_reg[3:2];
   wire logic [1:0] pwr_s     = sync2_reg[5:4];
   wire logic [1:0] trig_s    = sync2_reg[7:6];
   wire logic [1:0] iface_s   = sync2_reg[9:8];

   // the device samples on the rise and shifts out on the fall
   wire logic sclk_rise_w = sclk_s & ~sclk_d_reg;
   wire logic sclk_fall_w = ~sclk_s & sclk_d_reg;

   // other interface select codes leave the link deaf and silent
   wire logic serial_on_w = (iface_s == `VSGR_IFACE_SERIAL);

   wire logic [1:0] ch_oe_w;
   wire logic [1:0] ch_bit_w;

   // every pin, the link clock too, crosses in on two flip-flops
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         sync1_reg  <= `VSGR_SYNC_RESET;
         sync2_reg  <= `VSGR_SYNC_RESET;
         sclk_d_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sync1_reg  <= pins_w;
         sync2_reg  <= sync1_reg;
         sclk_d_reg <= sclk_s;
      end
   end

   // channel a has the line if the host wrongly selects both on readback
   wire logic sdio_oe_next = ch_oe_w[0] | ch_oe_w[1];
   wire logic sdio_next    = ch_oe_w[0] ? ch_bit_w[0] : ch_bit_w[1];

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         sdio_oe_reg  <= 1'b0;
         sdio_out_reg <= 1'b1;
      end
      else if (clk_en_i)
      begin
         sdio_oe_reg  <= sdio_oe_next;
         sdio_out_reg <= sdio_next;
      end
   end

   assign link.dev_sdio    = sdio_out_reg;
   assign link.dev_sdio_oe = sdio_oe_reg;

   for (genvar c = 0; c < `VSGR_NUM_CH; c++)
   begin : g_ch
      logic        sel_d_reg;
      logic        in_frame_reg;
      logic [4:0]  cnt_reg;
      logic [15:0] shin_reg;
      logic [15:0] shout_reg;
      logic [5:0]  gain_reg;
      logic [1:0]  atk_reg;
      logic        rd_pend_reg;
      logic        drive_reg;
      logic [5:0]  applied_reg;
      logic [6:0]  half_db_reg;
      logic        amp_on_reg;

      // each select frames its own channel, so both low write both
      wire logic start_w = serial_on_w & sel_d_reg & ~sel_n_s[c];
      wire logic stop_w  = in_frame_reg & sel_n_s[c];
      // only a frame of exactly sixteen rises counts
      wire logic full_w  = (cnt_reg == `VSGR_CNT_FULL);
      wire logic rd_req_w = shin_reg[`VSGR_RW_BIT];
      wire logic [6:0] sum_w = {1'b0, gain_reg} + attack_step(atk_reg);
      wire logic [5:0] cut_w = (sum_w > `VSGR_CODE_MAX) ?
                               6'(`VSGR_CODE_MAX) : sum_w[5:0];
      wire logic [5:0] applied_next = trig_s[c] ? cut_w : gain_reg;
      wire logic [6:0] half_db_next = `VSGR_HALF_DB_TOP - {1'b0, applied_reg};

      always_ff @(posedge ref_clk_i)
      begin
         if (!reset_n_i)
         begin
            sel_d_reg    <= 1'b1;
            in_frame_reg <= 1'b0;
            cnt_reg      <= 5'h00;
            shin_reg     <= 16'h0000;
            shout_reg    <= 16'h0000;
            gain_reg     <= `VSGR_GAIN_RESET;
            atk_reg      <= `VSGR_ATK_RESET;
            rd_pend_reg  <= 1'b0;
            drive_reg    <= 1'b0;
         end
         else if (clk_en_i)
         begin
            sel_d_reg <= sel_n_s[c];
            if (start_w)
            begin
               in_frame_reg <= 1'b1;
               cnt_reg      <= 5'h00;
               drive_reg    <= rd_pend_reg;
               shout_reg    <= pack_word(atk_reg, gain_reg);
            end
            else if (stop_w)
            begin
               in_frame_reg <= 1'b0;
               drive_reg    <= 1'b0;
               // short or long frames are dropped with nothing stored
               if (full_w)
               begin
                  if (drive_reg)
                     rd_pend_reg <= 1'b0;
                  else if (rd_req_w)
                     rd_pend_reg <= 1'b1;
                  else
                  begin
                     // only the low six and selector bits are kept
                     gain_reg <= shin_reg[`VSGR_GAIN_MSB:0];
                     atk_reg  <= shin_reg[`VSGR_ATK_HI_BIT:`VSGR_ATK_LO_BIT];
                  end
               end
            end
            else if (in_frame_reg)
            begin
               if (sclk_rise_w)
               begin
                  shin_reg <= {shin_reg[14:0], sdio_s};
                  if (cnt_reg != `VSGR_CNT_OVER)
                     cnt_reg <= cnt_reg + 5'h01;
               end
               if (sclk_fall_w && drive_reg)
                  shout_reg <= {shout_reg[14:0], 1'b0};
            end
         end
      end

      // fast attack adds the selected step to the code, held at 63
      always_ff @(posedge ref_clk_i)
      begin
         if (!reset_n_i)
         begin
            applied_reg <= `VSGR_GAIN_RESET;
            half_db_reg <= `VSGR_HALF_DB_TOP - {1'b0, `VSGR_GAIN_RESET};
            amp_on_reg  <= 1'b0;
         end
         else if (clk_en_i)
         begin
            applied_reg <= applied_next;
            half_db_reg <= half_db_next;
            amp_on_reg  <= pwr_s[c];
         end
      end

      assign ch_oe_w[c]        = drive_reg & in_frame_reg;
      assign ch_bit_w[c]       = shout_reg[15];
      assign gain_code_o[c]    = gain_reg;
      assign attack_sel_o[c]   = atk_reg;
      assign applied_code_o[c] = applied_reg;
      assign gain_half_db_o[c] = half_db_reg;
      assign amp_on_o[c]       = amp_on_reg;
      assign read_pending_o[c] = rd_pend_reg;
   end

endmodule : vsgr_device
`default_nettype wire

// file: logic/vsgr_defs.svh
// constants for the serial gain control word link, both ends
// Notes on behaviour
// - one transaction is exactly sixteen bits, select low
// - flag low stores six gain code bits
// - code zero least, sixty-three most attenuation
// - attack selector sets the fast attack step
// - ignored bit positions never change behaviour
// - flag high requests readback, stores nothing
// - next transaction device shifts stored word out
// - after readback the next transaction is write
// - code zero is +20 dB, 63 is -11.5 dB
// - each code step lowers gain 0.5 dB
// - power-up input low powers channel down
// - both selects low write both channels
// - host reads back one channel at a time
// - attack trigger high cuts gain 2/4/8/16 dB
// - serial link only when interface select is 01
`ifndef VSGR_DEFS_SVH
`define VSGR_DEFS_SVH

`define VSGR_NUM_CH         2
`define VSGR_WORD_W         16
`define VSGR_RW_BIT         15
`define VSGR_ATK_HI_BIT     7
`define VSGR_ATK_LO_BIT     6
`define VSGR_GAIN_MSB       5
`define VSGR_GAIN_RESET     6'h3f
`define VSGR_ATK_RESET      2'h0
`define VSGR_CODE_MAX       7'h3f
`define VSGR_STEP_BASE      7'h04
`define VSGR_HALF_DB_TOP    7'h28
`define VSGR_IFACE_SERIAL   2'h1
`define VSGR_CNT_FULL       5'h10
`define VSGR_CNT_OVER       5'h11
`define VSGR_SYNC_RESET     10'h00c
`define VSGR_CLK_PERIOD_NS  8
`define VSGR_SCLK_PERIOD_NS 80
`define VSGR_SCLK_HALF_CYC  ((`VSGR_SCLK_PERIOD_NS / `VSGR_CLK_PERIOD_NS) / 2)

`endif

// file: logic/vsgr_pkg.sv
// shared types for the serial gain control word link
`default_nettype none
package vsgr_pkg;

   typedef logic [15:0] vsgr_word_t;

   typedef enum logic [2:0]
   {
      host_idle = 3'b000,
      host_lead = 3'b001,
      host_high = 3'b010,
      host_low  = 3'b011,
      host_gap  = 3'b100
   } vsgr_host_state_t;

endpackage : vsgr_pkg
`default_nettype wire

// file: logic/vsgr_link_if.sv
// three-wire link between the host and the gain register device
`default_nettype none
interface vsgr_link_if;
   logic sclk;
   logic sel_a_n;
   logic sel_b_n;
   logic host_sdio;
   logic host_sdio_oe;
   logic dev_sdio;
   logic dev_sdio_oe;
   logic sdio;

   // weak pull-up when nobody drives; device wins a clash
   assign sdio = dev_sdio_oe ? dev_sdio : (host_sdio_oe ? host_sdio : 1'b1);

   modport host
   (
      output sclk,
      output sel_a_n,
      output sel_b_n,
      output host_sdio,
      output host_sdio_oe,
      input  sdio
   );

   modport dev
   (
      input  sclk,
      input  sel_a_n,
      input  sel_b_n,
      input  sdio,
      output dev_sdio,
      output dev_sdio_oe
   );
endinterface : vsgr_link_if
`default_nettype wire

// file: logic/vsgr_host.sv
// host end: drives one sixteen-bit serial transaction per command
`include "vsgr_defs.svh"
`default_nettype none
module vsgr_host
#(
   parameter int unsigned HALF_CYC = `VSGR_SCLK_HALF_CYC
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   vsgr_link_if.host        link,
   input  wire logic        cmd_valid_i,
   input  wire logic [1:0]  cmd_sel_i,
   input  wire logic        cmd_read_i,
   input  wire logic [15:0] cmd_word_i,
   output var  logic        cmd_ready_o,
   output var  logic        done_o,
   output var  logic [15:0] rd_word_o
);

   vsgr_pkg::vsgr_host_state_t state_reg;
   logic [7:0]                 tmr_reg;
   logic [4:0]                 bits_reg;
   logic                       rd_reg;
   vsgr_pkg::vsgr_word_t       tx_reg;
   vsgr_pkg::vsgr_word_t       rx_reg;
   logic                       sclk_reg;
   logic [1:0]                 sel_n_reg;
   logic                       oe_reg;
   logic                       sync1_reg;
   logic                       sync2_reg;

   wire logic tmr_done_w = (tmr_reg == 8'h00);
   wire logic [7:0] tmr_load_w = 8'(HALF_CYC - 1);
   wire logic take_w = cmd_valid_i & cmd_ready_o;
   // a readback with both selects would make both channels drive
   wire logic [1:0] sel_w = (cmd_read_i && cmd_sel_i == 2'h3) ?
                            2'h1 : cmd_sel_i;

   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         state_reg   <= vsgr_pkg::host_idle;
         tmr_reg     <= 8'h00;
         bits_reg    <= 5'h00;
         rd_reg      <= 1'b0;
         tx_reg      <= 16'h0000;
         rx_reg      <= 16'h0000;
         sclk_reg    <= 1'b0;
         sel_n_reg   <= 2'h3;
         oe_reg      <= 1'b0;
         sync1_reg   <= 1'b1;
         sync2_reg   <= 1'b1;
         cmd_ready_o <= 1'b0;
         done_o      <= 1'b0;
         rd_word_o   <= 16'h0000;
      end
      else if (clk_en_i)
      begin
         sync1_reg <= link.sdio;
         sync2_reg <= sync1_reg;
         done_o    <= 1'b0;
         if (!tmr_done_w)
            tmr_reg <= tmr_reg - 8'h01;
         case (state_reg)
            vsgr_pkg::host_idle:
            begin
               cmd_ready_o <= 1'b1;
               if (take_w)
               begin
                  cmd_ready_o <= 1'b0;
                  sel_n_reg   <= ~sel_w;
                  rd_reg      <= cmd_read_i;
                  oe_reg      <= ~cmd_read_i;
                  tx_reg      <= cmd_word_i;
                  bits_reg    <= 5'h00;
                  tmr_reg     <= tmr_load_w;
                  state_reg   <= vsgr_pkg::host_lead;
               end
            end
            vsgr_pkg::host_lead, vsgr_pkg::host_low:
               if (tmr_done_w)
               begin
                  tmr_reg <= tmr_load_w;
                  if (bits_reg == `VSGR_CNT_FULL)
                  begin
                     sel_n_reg <= 2'h3;
                     oe_reg    <= 1'b0;
                     done_o    <= 1'b1;
                     rd_word_o <= rx_reg;
                     state_reg <= vsgr_pkg::host_gap;
                  end
                  else
                  begin
                     sclk_reg  <= 1'b1;
                     state_reg <= vsgr_pkg::host_high;
                  end
               end
            vsgr_pkg::host_high:
               if (tmr_done_w)
               begin
                  // sampled at the end of high, well after the device shifted
                  rx_reg    <= {rx_reg[14:0], sync2_reg};
                  tx_reg    <= {tx_reg[14:0], 1'b0};
                  bits_reg  <= bits_reg + 5'h01;
                  sclk_reg  <= 1'b0;
                  tmr_reg   <= tmr_load_w;
                  state_reg <= vsgr_pkg::host_low;
               end
            vsgr_pkg::host_gap:
               if (tmr_done_w)
                  state_reg <= vsgr_pkg::host_idle;
            default:
               state_reg <= vsgr_pkg::host_idle;
         endcase
      end
   end

   assign link.sclk         = sclk_reg;
   assign link.sel_a_n      = sel_n_reg[0];
   assign link.sel_b_n      = sel_n_reg[1];
   assign link.host_sdio    = tx_reg[15];
   assign link.host_sdio_oe = oe_reg & ~rd_reg;

endmodule : vsgr_host
`default_nettype wire

// file: verif/vsgr_link_props.sv
// concurrent checks on the three-wire gain control link
`default_nettype none
module vsgr_link_props
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic sclk,
   input wire logic sel_a_n,
   input wire logic sel_b_n,
   input wire logic host_sdio,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio,
   input wire logic dev_sdio_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sclk_reg;
   logic [4:0] rise_cnt_reg;
   wire logic  idle;
   wire logic  sclk_rise;

   assign idle      = sel_a_n & sel_b_n;
   assign sclk_rise = sclk & ~sclk_reg;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   // rises of the open frame; cleared whenever no channel is selected
   always_ff @(posedge ref_clk_i)
   begin
      sclk_reg <= sclk;
      if (!reset_n_i || idle)
         rise_cnt_reg <= 5'h00;
      else if (sclk_rise)
         rise_cnt_reg <= rise_cnt_reg + 5'h01;
   end

   a_sclk_in_frame:
      assert property (sclk |-> !idle)
      else $error("serial clock high with no channel selected");
   a_frame_sixteen:
      assert property ($rose(idle) |-> rise_cnt_reg == 5'h10)
      else $error("frame closed after a count other than sixteen");
   a_sel_steady:
      assert property (sclk |-> $stable(sel_a_n) && $stable(sel_b_n))
      else $error("select moved while serial clock high");
   a_host_data_held:
      assert property (sclk && host_sdio_oe |-> $stable(host_sdio))
      else $error("host data moved while serial clock high");
   a_dev_data_held:
      assert property (sclk && $past(sclk) && dev_sdio_oe
                       |-> $stable(dev_sdio))
      else $error("device data moved while serial clock high");
   a_no_contention:
      assert property (!(dev_sdio_oe && host_sdio_oe))
      else $error("both ends drive the data line");
   a_host_oe_frame:
      assert property (host_sdio_oe |-> !idle)
      else $error("host drives data line outside a frame");
   a_dev_release:
      assert property (idle [*6] |-> !dev_sdio_oe)
      else $error("device still drives data line after frame");
endmodule : vsgr_link_props
`default_nettype wire

// file: verif/vga_serial_gain_register_tb.sv
// self-checking bench: host and device ends joined over the link
`default_nettype none
module vga_serial_gain_register_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic            ref_clk_i = 1'b0;
   logic            reset_n_i = 1'b0;
   logic            cmd_valid = 1'b0;
   logic [1:0]      cmd_sel   = 2'h0;
   logic            cmd_read  = 1'b0;
   logic [15:0]     cmd_word  = 16'h0000;
   logic [1:0]      pwr       = 2'h0;
   logic [1:0]      trig      = 2'h0;
   logic            if_lo     = 1'b1;
   logic            if_hi     = 1'b0;
   logic            dev_en    = 1'b1;
   logic            host_cut_n = 1'b1;
   logic            cmd_ready;
   logic            done;
   logic [15:0]     rd_word;
   logic [1:0][5:0] gain;
   logic [1:0][5:0] appl;
   logic [1:0][1:0] atk;
   logic [1:0][6:0] half_db;
   logic [1:0]      amp_on;
   logic [1:0]      pend;
   logic [5:0]      g;
   logic [1:0]      a;
   logic [6:0]      s;
   logic [6:0]      h;
   int              n_mismatch = 0;
   int              tests_run  = 0;

   always #4 ref_clk_i = ~ref_clk_i;

   vsgr_link_if link_if ();

   vsgr_host u_vsgr_host
   (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i & host_cut_n),
      .clk_en_i    (1'b1),
      .link        (link_if),
      .cmd_valid_i (cmd_valid),
      .cmd_sel_i   (cmd_sel),
      .cmd_read_i  (cmd_read),
      .cmd_word_i  (cmd_word),
      .cmd_ready_o (cmd_ready),
      .done_o      (done),
      .rd_word_o   (rd_word)
   );

   vsgr_device u_vsgr_device
   (
      .ref_clk_i             (ref_clk_i),
      .reset_n_i             (reset_n_i),
      .clk_en_i              (dev_en),
      .link                  (link_if),
      .power_up_ch_a_i       (pwr[0]),
      .power_up_ch_b_i       (pwr[1]),
      .attack_trigger_ch_a_i (trig[0]),
      .attack_trigger_ch_b_i (trig[1]),
      .iface_sel_hi_i        (if_hi),
      .iface_sel_lo_i        (if_lo),
      .gain_code_o           (gain),
      .attack_sel_o          (atk),
      .applied_code_o        (appl),
      .gain_half_db_o        (half_db),
      .amp_on_o              (amp_on),
      .read_pending_o        (pend)
   );

   vsgr_link_props u_vsgr_link_props
   (
      .ref_clk_i    (ref_clk_i),
      .reset_n_i    (reset_n_i & host_cut_n),
      .sclk         (link_if.sclk),
      .sel_a_n      (link_if.sel_a_n),
      .sel_b_n      (link_if.sel_b_n),
      .host_sdio    (link_if.host_sdio),
      .host_sdio_oe (link_if.host_sdio_oe),
      .dev_sdio     (link_if.dev_sdio),
      .dev_sdio_oe  (link_if.dev_sdio_oe)
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // one host command, then time for the synced device side to settle
   task automatic xfer(input logic [1:0] sl, input logic r,
                       input logic [15:0] w);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 500)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      @(posedge ref_clk_i);
      cmd_sel   <= sl;
      cmd_read  <= r;
      cmd_word  <= w;
      cmd_valid <= 1'b1;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      do
      begin
         @(negedge ref_clk_i);
         n++;
      end
      while (done !== 1'b1 && n < 1000);
      chk(16'(n < 1000), 16'h0001);
      repeat (12) @(negedge ref_clk_i);
   endtask : xfer

   initial
   begin
      repeat (6) @(negedge ref_clk_i);
      chk(16'(gain), 16'h0fff);
      chk(16'({atk, pend, amp_on}), 16'h0000);
      chk(16'(half_db), 16'({7'h69, 7'h69}));
      @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      pwr       <= 2'b01;
      repeat (8) @(negedge ref_clk_i);
      chk(16'(amp_on), 16'h0001);
      xfer(2'b01, 1'b0, 16'h7fc5);
      chk(16'({gain, atk}), 16'({6'h3f, 6'h05, 4'h3}));
      xfer(2'b11, 1'b0, 16'h0040);
      chk(16'({gain, atk}), 16'h0005);
      chk(16'(half_db[1]), 16'h0028);
      // four selector codes, then one that must saturate
      for (int i = 0; i < 5; i++)
      begin
         g = (i == 4) ? 6'h30 : 6'h10;
         a = (i == 4) ? 2'h3 : 2'(i);
         s = {1'b0, g} + (7'h04 << a);
         xfer(2'b10, 1'b0, {8'h00, a, g});
         @(posedge ref_clk_i);
         trig <= 2'b10;
         repeat (8) @(negedge ref_clk_i);
         chk(16'(appl[1]), 16'((s > 7'h3f) ? 7'h3f : s));
         chk(16'(appl[0]), 16'h0000);
         @(posedge ref_clk_i);
         trig <= 2'b00;
         repeat (8) @(negedge ref_clk_i);
         // kept at seven bits so a negative level wraps like the port
         h = 7'h28 - {1'b0, g};
         chk(16'(half_db[1]), 16'(h));
      end
      xfer(2'b10, 1'b0, 16'hff2a);
      chk(16'({gain[1], atk[1], pend}), 16'({6'h30, 2'h3, 2'h2}));
      xfer(2'b10, 1'b1, 16'h0000);
      chk(rd_word, 16'h00f0);
      chk(16'(pend), 16'h0000);
      xfer(2'b10, 1'b0, 16'h0007);
      chk(16'(gain[1]), 16'h0007);
      // host reset mid-word: the device sees eight rises and drops it
      @(posedge ref_clk_i);
      cmd_sel   <= 2'b10;
      cmd_read  <= 1'b0;
      cmd_word  <= 16'h0015;
      cmd_valid <= 1'b1;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      repeat (80) @(posedge ref_clk_i);
      host_cut_n <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      host_cut_n <= 1'b1;
      repeat (12) @(negedge ref_clk_i);
      chk(16'({gain[1], pend}), 16'({6'h07, 2'h0}));
      // a readback asked with both selects goes to channel a only
      xfer(2'b01, 1'b0, 16'h8000);
      xfer(2'b11, 1'b1, 16'h0000);
      chk(rd_word, 16'h0040);
      chk(16'(pend), 16'h0000);
      // frozen device ignores its pins until enabled again
      @(posedge ref_clk_i);
      dev_en <= 1'b0;
      pwr    <= 2'b11;
      repeat (8) @(negedge ref_clk_i);
      chk(16'(amp_on), 16'h0001);
      @(posedge ref_clk_i);
      dev_en <= 1'b1;
      repeat (8) @(negedge ref_clk_i);
      chk(16'(amp_on), 16'h0003);
      @(posedge ref_clk_i);
      if_lo <= 1'b0;
      xfer(2'b01, 1'b0, 16'h0011);
      chk(16'(gain[0]), 16'h0000);
      @(posedge ref_clk_i);
      if_hi <= 1'b1;
      if_lo <= 1'b1;
      xfer(2'b01, 1'b0, 16'h0012);
      chk(16'(gain[0]), 16'h0000);
      summarize();
   end

   // fifteen transfers need about 3,000 cycles; allow several times that
   initial
   begin
      #150000;
      n_mismatch++;
      summarize();
   end
endmodule : vga_serial_gain_register_tb
`default_nettype wire
